//--- logic/dimming_pwm_ctrl.sv
// Purpose: Dimming front end of a six channel LED driver: serial frame receiver,
//   DC code sampling, PWM generation, channel disable at startup, cascade forwarding
// Assumes: All pin inputs synchronous to clk; DC levels arrive as 8-bit codes
//   already scaled from the 0.8V..5.7V range by the converter in front
// Notes: Mode strap is caught once after reset release and then held
//
// Behaviour
// (R1) Serial mode leaves the fourth group input unused; board ties it low.
// (R2) A frame is exactly four bytes, one per channel group.
// (R3) Byte 00h gives zero duty, byte FFh gives full duty.
// (R4) Bytes go in order to channels 0/1, 2/3, 4, then 5.
// (R5) One data bit is captured on each rising serial clock edge.
// (R6) A frame-end falling edge after 32 bits commits the buffered bytes.
// (R7) Serial on time is byte value plus one out of 256 steps.
// (R8) Bytes one and two both give two steps of on time.
// (R9) Serial PWM period is 256 system clock cycles.
// (R10) Board picks a clock so one step is at least 8 us.
// (R11) DC mode samples each group and updates its duty every 1280 cycles.
// (R12) DC duty updates every 1280 cycles; PWM period stays 256 steps.
// (R13) DC codes map linearly to duty, zero at the low bound.
// (R14) Mode strap tied high selects DC dimming.
// (R15) Channels without a transistor at rail-ready are disabled for good.
// (R16) Board keeps channel zero populated; at most five unused.
// (R17) Serial mode forwards committed frames on strobe and shift clock.
// (R18) DC mode encodes sampled codes as serial bytes down the cascade.
// (R19) Direct mode slaves share strobe and clock pins with the master.
// (R20) Floating strap selects serial mode; tied low selects direct mode.
// (R21) Undriven group inputs read low, so the LED stays off.
// (R22) Serial bits arrive MSB first; first byte belongs to channels 0/1.
// (R23) Duties hold until a complete frame is committed.
// (R24) Data is the first group input, frame end the third.
`timescale 1ns/1ps
`include "dimming_cfg.svh"
module dimming_pwm_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_strap_high,
  input wire logic mode_strap_low,
  input wire logic group_a_dim_input,
  input wire logic serial_bit_clock_input,
  input wire logic group_c_dim_input,
  input wire logic group_d_dim_input,
  input wire logic [7:0] dc_code_a,
  input wire logic [7:0] dc_code_b,
  input wire logic [7:0] dc_code_c,
  input wire logic [7:0] dc_code_d,
  input wire logic rail_ready_level,
  input wire logic [5:0] channel_drain_sense,
  output logic [5:0] channel_gate_drive,
  output logic [5:0] channel_enabled,
  output dimming_pkg::mode_type active_mode,
  output logic cascade_shift_clock_out,
  output logic cascade_strobe_out,
  output logic cascade_data_out
);
  import dimming_pkg::*;

  // Group that drives a given output channel
  function automatic logic [1:0] group_of(input int ch);
    case (ch)
      0, 1: group_of = 2'h0;
      2, 3: group_of = 2'h1;
      4: group_of = 2'h2;
      default: group_of = 2'h3;
    endcase
  endfunction

  // PWM compare: off for byte 00h, else on while the step count is at or below the duty byte;
  // byte 02h is folded onto the two-step minimum shared with byte 01h
  function automatic logic duty_on(input logic [7:0] duty, input logic [7:0] step);
    if (duty == 8'h00) begin
      duty_on = 1'b0; // R3
    end else if (duty == 8'h02) begin
      duty_on = (step <= 8'h01); // R8
    end else begin
      duty_on = (step <= duty); // R7 R8
    end
  endfunction

  // Mode strap and startup state
  logic strap_done_reg;
  mode_type mode_reg;

  // Serial receiver
  logic bit_clk_prev_reg;
  logic frame_prev_reg;
  logic [31:0] shift_in_reg;
  logic [`BIT_CNT_W-1:0] bit_cnt_reg;
  logic bit_rise;
  logic frame_fall;
  logic frame_commit;

  // Duty store and PWM
  logic [7:0] duty_reg [`GROUP_COUNT];
  logic [7:0] pwm_step_reg;
  logic [`DC_CNT_W-1:0] dc_cnt_reg;
  logic dc_tick;
  logic [3:0] group_level;
  logic rail_seen_reg;
  logic [5:0] enabled_reg;
  logic [5:0] gate_reg;

  // Cascade path
  logic forward_req_reg;
  logic push_busy_reg;
  logic [1:0] push_idx_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  shift_state_type sh_state_reg;
  logic [`SHIFT_CNT_W-1:0] half_cnt_reg;
  logic half_done;
  logic [7:0] shift_out_reg;
  logic [2:0] out_bit_reg;
  logic [1:0] out_byte_reg;
  logic sclk_reg;
  logic strobe_reg;
  logic sdata_reg;

  // Strap caught on the first edge after release; high wins over low if both set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_reg <= 1'b0;
      mode_reg <= MODE_SERIAL;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      if (mode_strap_high) begin
        mode_reg <= MODE_DC; // R14
      end else if (mode_strap_low) begin
        mode_reg <= MODE_DIRECT; // R20
      end else begin
        mode_reg <= MODE_SERIAL; // R20
      end
    end
  end

  // Edge detectors on the serial pins; inputs are already in the clk domain
  assign bit_rise = serial_bit_clock_input & ~bit_clk_prev_reg; // R5
  assign frame_fall = ~group_c_dim_input & frame_prev_reg; // R24
  assign frame_commit = frame_fall && (bit_cnt_reg == `BIT_CNT_W'(`FRAME_BITS)); // R6 R2

  // Previous pin levels; frame line idles high so reset to high avoids a false edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_clk_prev_reg <= 1'b0;
      frame_prev_reg <= 1'b1;
    end else begin
      bit_clk_prev_reg <= serial_bit_clock_input;
      frame_prev_reg <= group_c_dim_input;
    end
  end

  // Shift register: MSB first, bits beyond 32 ignored until the frame end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_in_reg <= 32'h0000_0000;
      bit_cnt_reg <= '0;
    end else if (mode_reg != MODE_SERIAL) begin
      bit_cnt_reg <= '0;
    end else if (frame_fall) begin
      bit_cnt_reg <= '0; // R6
    end else if (bit_rise && bit_cnt_reg != `BIT_CNT_W'(`FRAME_BITS)) begin
      shift_in_reg <= {shift_in_reg[30:0], group_a_dim_input}; // R5 R22 R24
      bit_cnt_reg <= bit_cnt_reg + `BIT_CNT_W'(1);
    end
  end

  // DC sampling interval counter
  assign dc_tick = (dc_cnt_reg == `DC_CNT_W'(`DC_UPDATE_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dc_cnt_reg <= '0;
    end else if (mode_reg != MODE_DC || dc_tick) begin
      dc_cnt_reg <= '0; // R11
    end else begin
      dc_cnt_reg <= dc_cnt_reg + `DC_CNT_W'(1);
    end
  end

  // Duty store: only a full frame or a DC sample changes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int g = 0; g < `GROUP_COUNT; g++) begin
        duty_reg[g] <= `DUTY_RESET;
      end
    end else if (mode_reg == MODE_SERIAL && frame_commit) begin
      duty_reg[0] <= shift_in_reg[31:24]; // R4 R22 R23
      duty_reg[1] <= shift_in_reg[23:16]; // R4
      duty_reg[2] <= shift_in_reg[15:8]; // R4
      duty_reg[3] <= shift_in_reg[7:0]; // R4
    end else if (mode_reg == MODE_DC && dc_tick) begin
      duty_reg[0] <= dc_code_a; // R11 R13
      duty_reg[1] <= dc_code_b;
      duty_reg[2] <= dc_code_c;
      duty_reg[3] <= dc_code_d;
    end
  end

  // Free running 256-step PWM period in every mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_step_reg <= 8'h00;
    end else begin
      pwm_step_reg <= pwm_step_reg + 8'h01; // R9 R12
    end
  end

  // Channel test happens once, at the first rail-ready level after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rail_seen_reg <= 1'b0;
      enabled_reg <= `ENABLE_RESET;
    end else if (rail_ready_level && !rail_seen_reg) begin
      rail_seen_reg <= 1'b1;
      enabled_reg <= channel_drain_sense; // R15
    end
  end

  // Direct mode levels; the pins are pulled low when undriven
  assign group_level = {group_d_dim_input, group_c_dim_input,
                        serial_bit_clock_input, group_a_dim_input}; // R21

  // Per-channel gate drive, registered so the pins never glitch
  generate
    for (genvar ch = 0; ch < `CHANNEL_COUNT; ch++) begin : g_chan
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          gate_reg[ch] <= 1'b0;
        end else if (!enabled_reg[ch]) begin
          gate_reg[ch] <= 1'b0; // R15
        end else if (mode_reg == MODE_DIRECT) begin
          gate_reg[ch] <= group_level[group_of(ch)]; // R20 R21
        end else begin
          gate_reg[ch] <= duty_on(duty_reg[group_of(ch)], pwm_step_reg); // R7 R3
        end
      end
    end
  endgenerate

  // Forward request raised on the same clock edge that the duty store takes the new bytes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      forward_req_reg <= 1'b0;
    end else begin
      forward_req_reg <= (mode_reg == MODE_SERIAL && frame_commit) || // R17
                         (mode_reg == MODE_DC && dc_tick); // R18
    end
  end

  // Pusher copies four duty bytes into the FIFO; it stalls while the FIFO is full.
  // A request arriving while a copy is still in progress is dropped, which keeps
  // frames whole on the cascade at the cost of skipping an update.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      push_busy_reg <= 1'b0;
      push_idx_reg <= 2'h0;
    end else if (!push_busy_reg) begin
      if (forward_req_reg) begin
        push_busy_reg <= 1'b1;
        push_idx_reg <= 2'h0;
      end
    end else if (fifo_in_ready) begin
      push_idx_reg <= push_idx_reg + 2'h1;
      if (push_idx_reg == 2'h3) begin
        push_busy_reg <= 1'b0;
      end
    end
  end

  byte_fifo #(
    .WIDTH(`DUTY_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push_busy_reg),
    .in_ready(fifo_in_ready),
    .in_data(duty_reg[push_idx_reg]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Shifter takes a byte only when idle
  assign fifo_out_ready = (sh_state_reg == SH_IDLE);
  assign half_done = (half_cnt_reg == `SHIFT_CNT_W'(`SHIFT_HALF_CYCLES - 1));

  // Half-period timer for shift clock and strobe phases
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_cnt_reg <= '0;
    end else if (sh_state_reg == SH_IDLE || half_done) begin
      half_cnt_reg <= '0;
    end else begin
      half_cnt_reg <= half_cnt_reg + `SHIFT_CNT_W'(1);
    end
  end

  // Cascade shifter: data set while clock low, sampled by the slave on the rise;
  // after the fourth byte the strobe falls for one half period to end the frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_state_reg <= SH_IDLE;
      shift_out_reg <= 8'h00;
      out_bit_reg <= 3'h0;
      out_byte_reg <= 2'h0;
      sclk_reg <= 1'b0;
      strobe_reg <= 1'b1;
      sdata_reg <= 1'b0;
    end else begin
      case (sh_state_reg)
        SH_IDLE: begin
          if (fifo_out_valid) begin
            shift_out_reg <= fifo_out_data;
            sdata_reg <= fifo_out_data[7]; // R22
            out_bit_reg <= 3'h0;
            sh_state_reg <= SH_LOW;
          end
        end
        SH_LOW: begin
          if (half_done) begin
            sclk_reg <= 1'b1; // R17 R18
            sh_state_reg <= SH_HIGH;
          end
        end
        SH_HIGH: begin
          if (half_done) begin
            sclk_reg <= 1'b0;
            if (out_bit_reg == 3'h7) begin
              out_byte_reg <= out_byte_reg + 2'h1;
              if (out_byte_reg == 2'h3) begin
                strobe_reg <= 1'b0; // R2
                sh_state_reg <= SH_STROBE;
              end else begin
                sh_state_reg <= SH_IDLE;
              end
            end else begin
              shift_out_reg <= {shift_out_reg[6:0], 1'b0};
              sdata_reg <= shift_out_reg[6];
              out_bit_reg <= out_bit_reg + 3'h1;
              sh_state_reg <= SH_LOW;
            end
          end
        end
        SH_STROBE: begin
          if (half_done) begin
            strobe_reg <= 1'b1;
            sh_state_reg <= SH_IDLE;
          end
        end
        default: begin
          sh_state_reg <= SH_IDLE;
        end
      endcase
    end
  end

  // Every output comes from a flip-flop
  assign channel_gate_drive = gate_reg;
  assign channel_enabled = enabled_reg;
  assign active_mode = mode_reg;
  assign cascade_shift_clock_out = sclk_reg;
  assign cascade_strobe_out = strobe_reg;
  assign cascade_data_out = sdata_reg;
endmodule

//--- shared/dimming_cfg.svh
// Purpose: Timing counts, field positions and reset values of the dimming front end
// Assumes: System clock slow enough that one PWM step lasts 8 us or more
// Notes: Included by dimming_pwm_ctrl only; the package and byte_fifo do not include it
`ifndef DIMMING_CFG_SVH
`define DIMMING_CFG_SVH

// One duty byte per channel group
`define DUTY_W 8
`define GROUP_COUNT 4
`define CHANNEL_COUNT 6
`define FRAME_BITS 32
`define BIT_CNT_W 6

// PWM period in system clock steps
`define PWM_STEPS 256
// DC sampling interval in system clock cycles
`define DC_UPDATE_CYCLES 1280
`define DC_CNT_W 11

// Half period of the cascade shift clock, in system clock cycles
`define SHIFT_HALF_CYCLES 4
`define SHIFT_CNT_W 3

// Cascade byte buffer
`define FIFO_DEPTH 16

// Reset values
`define DUTY_RESET 8'h00
`define ENABLE_RESET 6'h00

`endif

//--- shared/dimming_pkg.sv
// Purpose: Types shared by the dimming front end
// Assumes: Nothing beyond the constants header
// Notes: Numbers live in the header, types live here
package dimming_pkg;

  // Dimming mode picked by the mode strap
  typedef enum logic [1:0] {
    MODE_SERIAL,
    MODE_DC,
    MODE_DIRECT
  } mode_type;

  // Cascade output shifter phases
  typedef enum logic [1:0] {
    SH_IDLE,
    SH_LOW,
    SH_HIGH,
    SH_STROBE
  } shift_state_type;

endpackage

//--- logic/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, DEPTH a power of two
// Notes: in_ready drops when full, out_valid drops when empty
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_push;
  logic do_pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (count_reg != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  // Storage has no reset; it is only read when the count says valid
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

//--- verification/dimming_chk.sv
// Purpose: Port checker for the dimming front end
// Assumes: One clock, asynchronous active-low reset
// Notes: PWM on-counts are judged by the bench
`timescale 1ns/1ps
module dimming_chk
  import dimming_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic group_a_dim_input,
  input wire logic serial_bit_clock_input,
  input wire logic group_c_dim_input,
  input wire logic group_d_dim_input,
  input wire logic rail_ready_level,
  input wire logic [5:0] channel_drain_sense,
  input wire logic [5:0] channel_gate_drive,
  input wire logic [5:0] channel_enabled,
  input wire dimming_pkg::mode_type active_mode,
  input wire logic cascade_shift_clock_out,
  input wire logic cascade_strobe_out,
  input wire logic cascade_data_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [5:0] dmap;
  // Direct mode pin to channel fan-out
  assign dmap = {group_d_dim_input, group_c_dim_input, {2{serial_bit_clock_input}},
    {2{group_a_dim_input}}};
  a_disabled_off: assert property ((channel_gate_drive & ~channel_enabled) == 6'h00)
    else $error("gate driven on a disabled channel");
  a_enable_latch: assert property (channel_enabled == 6'h00 && rail_ready_level
    |=> channel_enabled == $past(channel_drain_sense)) else $error("presence not latched");
  a_enable_hold: assert property (channel_enabled != 6'h00 |=> $stable(channel_enabled))
    else $error("presence mask changed");
  a_mode_hold: assert property ($past(resetn, 2) |-> $stable(active_mode))
    else $error("mode changed after strap capture");
  a_strobe_pulse: assert property ($fell(cascade_strobe_out)
    |-> (!cascade_strobe_out)[*4] ##1 cascade_strobe_out) else $error("strobe pulse length");
  a_shift_high: assert property ($rose(cascade_shift_clock_out)
    |-> cascade_shift_clock_out[*4] ##1 !cascade_shift_clock_out) else $error("shift high time");
  a_data_hold: assert property (cascade_shift_clock_out |-> $stable(cascade_data_out))
    else $error("cascade data moved while shift clock high");
  a_direct_gate: assert property (active_mode == MODE_DIRECT && $stable(channel_enabled)
    |=> !$stable(channel_enabled) || channel_gate_drive == ($past(dmap) & channel_enabled))
    else $error("direct gate mismatch");
  c_strobe: cover property ($fell(cascade_strobe_out));
  c_dc_cascade: cover property (active_mode == MODE_DC ##1 $rose(cascade_shift_clock_out));
  c_direct_on: cover property (active_mode == MODE_DIRECT && channel_gate_drive != 6'h00);
endmodule
bind dimming_pwm_ctrl dimming_chk dimming_chk_inst (.clk, .resetn, .group_a_dim_input,
  .serial_bit_clock_input, .group_c_dim_input, .group_d_dim_input, .rail_ready_level,
  .channel_drain_sense, .channel_gate_drive, .channel_enabled, .active_mode,
  .cascade_shift_clock_out, .cascade_strobe_out, .cascade_data_out);

//--- verification/dim_partner.sv
// Purpose: Serial dimming controller plus one cascaded slave
// Assumes: Tasks are entered just after a clock edge
// Notes: Slave takes its word on the strobe falling edge
`timescale 1ns/1ps
module dim_partner (
  input wire logic clk,
  input wire logic shift_clk,
  input wire logic strobe,
  input wire logic sdata,
  output logic data_line,
  output logic bit_clk,
  output logic frame_end,
  output logic spare_line,
  output logic [31:0] slave_word,
  output int slave_frames
);
  logic [31:0] shreg;
  // Idle lines; spare group input held low in serial use
  initial begin
    data_line = 1'b0;
    bit_clk = 1'b0;
    frame_end = 1'b1;
    spare_line = 1'b0;
    shreg = 32'h0;
    slave_word = 32'h0;
    slave_frames = 0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Levels held two cycles so the sampler never misses one
  task automatic send(input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      data_line = (i < 32) ? w[31 - i] : 1'b0;
      cyc(2);
      bit_clk = 1'b1;
      cyc(2);
      bit_clk = 1'b0;
    end
    data_line = ~data_line;
    cyc(2);
    frame_end = 1'b0;
    cyc(2);
    frame_end = 1'b1;
    cyc(2);
  endtask
  task automatic levels(input logic [3:0] v);
    {spare_line, frame_end, bit_clk, data_line} = v;
  endtask
  // Slave shifts on the shift clock rise
  always @(posedge shift_clk) shreg <= {shreg[30:0], sdata};
  always @(negedge strobe) begin
    slave_word <= shreg;
    slave_frames <= slave_frames + 1;
  end
endmodule

//--- verification/testbench.sv
// Purpose: Self-checking bench for the dimming front end
// Assumes: 40 MHz clock; straps caught after each reset
// Notes: Random words come from a 16-bit LFSR seeded at 24
`timescale 1ns/1ps
module testbench;
  import dimming_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic strap_h = 1'b0;
  logic strap_l = 1'b0;
  logic rail = 1'b1;
  logic [5:0] drain = 6'h2F;
  logic [7:0] code [4];
  logic a, b, c, d, sclk_o, strobe_o, data_o;
  logic [5:0] gate, en, em;
  mode_type mode;
  logic [31:0] word;
  int frames;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] rnd = 16'h0018;
  // Fast bench clock; a board slows it so one duty step lasts 8 us or more
  initial begin
    forever #12.5 clk = ~clk;
  end
  dimming_pwm_ctrl dimming_pwm_ctrl_inst (.clk(clk), .resetn(resetn),
    .mode_strap_high(strap_h), .mode_strap_low(strap_l), .group_a_dim_input(a),
    .serial_bit_clock_input(b), .group_c_dim_input(c), .group_d_dim_input(d),
    .dc_code_a(code[0]), .dc_code_b(code[1]), .dc_code_c(code[2]), .dc_code_d(code[3]),
    .rail_ready_level(rail), .channel_drain_sense(drain), .channel_gate_drive(gate),
    .channel_enabled(en), .active_mode(mode), .cascade_shift_clock_out(sclk_o),
    .cascade_strobe_out(strobe_o), .cascade_data_out(data_o));
  dim_partner dim_partner_inst (.clk(clk), .shift_clk(sclk_o), .strobe(strobe_o),
    .sdata(data_o), .data_line(a), .bit_clk(b), .frame_end(c), .spare_line(d),
    .slave_word(word), .slave_frames(frames));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  // On steps per 256-step period for one duty byte; bytes 01h and 02h both give two
  function automatic logic [31:0] on_steps(input logic [7:0] v);
    return (v == 8'h00) ? 32'h0 : (v == 8'h02) ? 32'h2 : 32'h1 + v;
  endfunction
  function automatic logic [7:0] sel(input logic [31:0] w, input int ch);
    int i;
    i = (ch < 2) ? 0 : (ch < 4) ? 1 : ch - 2;
    return w[31 - 8 * i -: 8];
  endfunction
  function automatic logic [5:0] dmap(input logic [3:0] v);
    return {v[3], v[2], {2{v[1]}}, {2{v[0]}}} & em;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic nxt(output logic [31:0] w);
    rnd = lfsr(rnd);
    w[31:16] = rnd;
    rnd = lfsr(rnd);
    w[15:0] = rnd;
  endtask
  task automatic rst(input logic h, input logic l);
    resetn = 1'b0;
    strap_h = h;
    strap_l = l;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    em = drain;
    cyc(3);
  endtask
  // Slave frame count bounded wait; cascade frames take about 270 cycles
  task automatic wcas(input int t);
    for (int i = 0; i < 3000 && frames < t; i++) cyc(1);
  endtask
  // Window of 256 cycles matches one period only if the period is 256
  task automatic meas(input logic [31:0] w);
    logic [31:0] cnt [6];
    cnt = '{default: 32'h0};
    for (int i = 0; i < 256; i++) begin
      cyc(1);
      for (int k = 0; k < 6; k++) cnt[k] += gate[k];
    end
    for (int k = 0; k < 6; k++) chk(cnt[k], em[k] ? on_steps(sel(w, k)) : 32'h0);
  endtask
  task automatic frame(input logic [31:0] w, input int n);
    int f;
    f = frames;
    dim_partner_inst.send(w, n);
    wcas(f + 1);
    chk(word, w);
    meas(w);
  endtask
  task automatic close_out();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    close_out();
  end
  // Serial mode, then DC mode, then direct mode
  initial begin
    logic [31:0] w, w2;
    int f;
    code = '{8'h00, 8'h00, 8'h00, 8'h00};
    rst(1'b0, 1'b0);
    chk(mode, MODE_SERIAL);
    chk(en, 6'h2F);
    drain = 6'h3F;
    cyc(2);
    chk(en, 6'h2F);
    for (int i = 0; i < 6; i++) begin
      nxt(w);
      w = (i == 0) ? 32'h00FF0102 : (i == 1) ? 32'h0280FE7F : w;
      frame(w, 32);
    end
    nxt(w2);
    dim_partner_inst.send(w2, 31);
    meas(w);
    frame(w2, 33);
    f = frames;
    for (int i = 0; i < 3; i++) begin
      nxt(w);
      dim_partner_inst.send(w, 32);
    end
    wcas(f + 3);
    chk(frames, f + 3);
    chk(word, w);
    nxt(w);
    w[31:24] = 8'hFF;
    w[7:0] = 8'h00;
    {code[0], code[1], code[2], code[3]} = w;
    rst(1'b1, 1'b0);
    chk(mode, MODE_DC);
    wcas(frames + 1);
    chk(word, w);
    meas(w);
    {code[0], code[1], code[2], code[3]} = ~w;
    meas(w);
    wcas(frames + 1);
    chk(word, ~w);
    meas(~w);
    rst(1'b0, 1'b1);
    chk(mode, MODE_DIRECT);
    for (int v = 0; v < 16; v += 5) begin
      dim_partner_inst.levels(v[3:0]);
      cyc(2);
      chk(gate, dmap(v[3:0]));
      chk({sclk_o, strobe_o}, 32'h1);
    end
    close_out();
  end
endmodule
